// ==== hdl/tsw_top.sv ====
`timescale 1ns/100ps
`include "tsw_cfg.svh"
module tsw_top
  import tsw_pkg::*;
#(
  parameter int TS_W  = 64,
  parameter int CYC_W = 16,
  parameter int LIMIT = `TSW_DIST_LIMIT
) (
  input  wire logic              CLOCK,
  input  wire logic              RESETN,
  input  wire logic              CE,
  input  wire logic              PSEL,
  input  wire logic              PENABLE,
  input  wire logic              PWRITE,
  input  wire logic [11:0]       PADDR,
  input  wire logic [31:0]       PWDATA,
  output logic      [31:0]       PRDATA,
  output logic                   PREADY,
  output logic                   PSLVERR,
  input  wire logic              TRACE_ON,
  input  wire logic              DBG_EXIT,
  input  wire logic [31:0]       DBG_PC,
  input  wire logic              PROHIB_EXIT,
  input  wire logic              ALT_EXIT,
  input  wire logic              EXT_SYNC_REQ,
  input  wire logic [2:0]        INSN_BYTES,
  input  wire logic              WP_VALID,
  output logic                   WP_READY,
  input  wire logic [31:0]       WP_ADDR,
  input  wire logic              WP_ISIZE4,
  input  wire logic [31:0]       WP_TARGET,
  input  wire logic [1:0]        WP_ISA,
  input  wire logic              WP_NS,
  input  wire logic              WP_TAKEN,
  input  wire logic              WP_EXC_UPD,
  input  wire logic [31:0]       CTXID,
  input  wire logic [7:0]        VM_IDENT,
  input  wire logic [TS_W-1:0]   TIMESTAMP,
  input  wire logic              FIFO_ROOM,
  input  wire logic              FIFO_EMPTY,
  input  wire logic              FIFO_FULL,
  output logic                   TRACE_STOP,
  output logic                   PKT_VALID,
  input  wire logic              PKT_READY,
  output tsw_pkt_e               PKT_KIND,
  output logic      [31:0]       PKT_ADDR,
  output logic      [1:0]        PKT_REASON,
  output logic      [1:0]        PKT_ISA,
  output logic                   PKT_NS,
  output logic                   PKT_TAKEN,
  output logic      [31:0]       PKT_CTX,
  output logic                   PKT_CTX_VLD,
  output logic      [CYC_W-1:0]  PKT_CYC,
  output logic                   PKT_CYC_VLD,
  output logic      [TS_W-1:0]   PKT_TS,
  output logic      [7:0]        PKT_VM
);

  initial begin
    if (TS_W < 1 || TS_W > 64 || CYC_W < 4 || CYC_W > 32) begin
      $error("tsw_top: TS_W or CYC_W out of range");
    end
  end

  typedef struct packed {
    tsw_state_e        state;
    logic              prog;
    logic              oslock;
    logic              ctx_en;
    logic              cyc_en;
    logic [11:0]       freq;
    logic [11:0]       per_cnt;
    logic [3:0]        pend;
    logic [3:0]        svc;
    logic              ovf;
    logic              ton_pend;
    logic [1:0]        ton_rsn;
    logic              was_en;
    logic              ext_prev;
    logic              seq_full;
    logic [1:0]        seq_rsn;
    logic [31:0]       dbg_pc;
    logic [31:0]       last_tgt;
    logic [1:0]        last_isa;
    logic              last_ns;
    logic [31:0]       upd_addr;
    logic              wp_taken;
    logic [CYC_W-1:0]  cyc_run;
    logic [CYC_W-1:0]  cyc_wp;
    logic              pkt_valid;
    tsw_pkt_e          pkt_kind;
    logic [31:0]       pkt_addr;
    logic [1:0]        pkt_rsn;
    logic [1:0]        pkt_isa;
    logic              pkt_ns;
    logic              pkt_taken;
    logic [31:0]       pkt_ctx;
    logic              pkt_ctx_vld;
    logic [CYC_W-1:0]  pkt_cyc;
    logic              pkt_cyc_vld;
    logic [TS_W-1:0]   pkt_ts;
    logic [7:0]        pkt_vm;
    logic [31:0]       prdata;
    logic              pslverr;
  } tsw_top_s;

  localparam tsw_top_s RST_VAL = '{
    state:    ST_IDLE,
    pkt_kind: PK_ASYNC,
    prog:     `TSW_PROG_RST,
    oslock:   `TSW_OSLOCK_RST,
    freq:     `TSW_FREQ_RST,
    pend:     `TSW_PEND_RST,
    default:  '0
  };

  tsw_top_s r_reg;
  tsw_top_s r_next;

  logic       ext_req;
  logic       trace_en;
  logic       bus_wr;
  logic       bus_setup;
  logic [3:0] req;
  logic       forced;
  logic       out_free;
  logic       sync_go;
  logic       in_seq;
  logic       wp_take;

  tsw_dist_if dif ();

  // external request pin comes from another domain
  tsw_sync3 u_ext_sync (
    .clk   (CLOCK),
    .rst_n (RESETN),
    .ce    (CE),
    .d     (EXT_SYNC_REQ),
    .q     (ext_req)
  );

  tsw_dist #(
    .LIMIT (LIMIT)
  ) u_dist (
    .clk   (CLOCK),
    .rst_n (RESETN),
    .ce    (CE),
    .dif   (dif)
  );

  // bus phases: write lands at the access edge, read data prepared in setup
  assign bus_wr    = PSEL & PENABLE & PWRITE;
  assign bus_setup = PSEL & ~PENABLE;
  assign trace_en  = TRACE_ON & ~r_reg.prog & ~r_reg.oslock;

  // the four sync request sources
  always_comb begin
    req = '0;
    req[`TSW_SRC_PROG] = bus_wr && PADDR == `TSW_OFS_CTRL && r_reg.prog
                         && !PWDATA[`TSW_CTRL_PROG];
    req[`TSW_SRC_OSL]  = bus_wr && PADDR == `TSW_OFS_OSLOCK && r_reg.oslock
                         && !PWDATA[`TSW_OSLOCK_BIT];
    req[`TSW_SRC_CNT]  = trace_en && r_reg.freq != 12'h000
                         && r_reg.per_cnt == r_reg.freq;
    req[`TSW_SRC_EXT]  = ext_req & ~r_reg.ext_prev;
  end

  // sequence states, where a repeat from a served source means trouble
  assign in_seq = r_reg.state == ST_ASYNC || r_reg.state == ST_ISYNC
                  || r_reg.state == ST_VIRTUAL_MACHINE_IDENTIFIER || r_reg.state == ST_TSYNC;
  assign forced = (in_seq && |(req & r_reg.svc))
                  || (trace_en && FIFO_FULL && r_reg.state != ST_DRAIN);
  assign sync_go = trace_en && (|r_reg.pend || r_reg.ovf);

  // output slot free; sync packets also need fifo room
  assign out_free = ~r_reg.pkt_valid | PKT_READY;

  // waypoints are absorbed while trace is off so targets stay current
  assign WP_READY = !trace_en || (r_reg.state == ST_IDLE && !forced && !sync_go
                    && !r_reg.ton_pend);
  assign wp_take  = WP_VALID & WP_READY;

  // distance counter steered from here
  assign dif.step = trace_en ? INSN_BYTES : 3'h0;
  assign dif.clr  = wp_take
                    || (r_reg.state == ST_ISYNC && out_free && FIFO_ROOM);

  // next-state logic for everything the block keeps
  always_comb begin
    r_next          = r_reg;
    r_next.was_en   = trace_en;
    r_next.ext_prev = ext_req;
    if (r_reg.cyc_run != {CYC_W{1'b1}}) begin
      r_next.cyc_run = r_reg.cyc_run + 1'b1;
    end

    // register writes
    if (bus_wr) begin
      case (PADDR)
        `TSW_OFS_CTRL: begin
          r_next.prog   = PWDATA[`TSW_CTRL_PROG];
          r_next.ctx_en = PWDATA[`TSW_CTRL_CTXEN];
          r_next.cyc_en = PWDATA[`TSW_CTRL_CYCEN];
        end
        `TSW_OFS_OSLOCK: r_next.oslock = PWDATA[`TSW_OSLOCK_BIT];
        `TSW_OFS_FREQ:   r_next.freq   = PWDATA[11:0];
        default:         r_next.freq   = r_reg.freq;
      endcase
    end

    // read data and error captured in setup, held through access
    if (bus_setup) begin
      r_next.pslverr = 1'b0;
      case (PADDR)
        `TSW_OFS_CTRL:   r_next.prdata = {29'h0, r_reg.cyc_en, r_reg.ctx_en, r_reg.prog};
        `TSW_OFS_OSLOCK: r_next.prdata = {31'h0, r_reg.oslock};
        `TSW_OFS_FREQ:   r_next.prdata = {20'h0, r_reg.freq};
        `TSW_OFS_STATUS: r_next.prdata = {18'h0, trace_en, r_reg.ton_pend, r_reg.ovf,
                                          r_reg.svc, r_reg.pend, r_reg.state};
        default: begin
          r_next.prdata  = 32'h0;
          r_next.pslverr = 1'b1;
        end
      endcase
    end

    // periodic counter runs only while tracing; reaching a nonzero freq raises a request and restarts it
    if (trace_en) begin
      r_next.per_cnt = req[`TSW_SRC_CNT] ? 12'h000 : r_reg.per_cnt + 12'h001;
    end

    // turn-on events; debug exit wins the reason and keeps its pc
    if (trace_en && !r_reg.was_en) begin
      r_next.ton_pend = 1'b1;
      r_next.ton_rsn  = `TSW_RSN_TURNON;
    end
    if (PROHIB_EXIT || ALT_EXIT) begin
      r_next.ton_pend = 1'b1;
      r_next.ton_rsn  = `TSW_RSN_TURNON;
    end
    if (DBG_EXIT) begin
      r_next.ton_pend = 1'b1;
      r_next.ton_rsn  = `TSW_RSN_DEBUG;
      r_next.dbg_pc   = DBG_PC;
    end

    // new requests pend; a set in the same cycle as service start wins
    r_next.pend = r_reg.pend | (req & ~(in_seq ? r_reg.svc : 4'h0));

    // packet leaves when the sink takes it
    if (r_reg.pkt_valid && PKT_READY) begin
      r_next.pkt_valid = 1'b0;
    end

    // waypoint capture, also while trace is off
    if (wp_take) begin
      r_next.last_tgt = WP_TARGET;
      r_next.last_isa = WP_ISA;
      r_next.last_ns  = WP_NS;
      r_next.wp_taken = WP_TAKEN;
      r_next.cyc_wp   = r_reg.cyc_run;
      r_next.upd_addr = WP_ADDR - (WP_ISIZE4 ? 32'h4 : 32'h2);
    end

    case (r_reg.state)
      ST_IDLE: begin
        if (forced) begin
          r_next.state = ST_DRAIN;
          r_next.svc   = 4'h0;
        end else if (sync_go) begin
          r_next.state    = ST_ASYNC;
          r_next.svc      = r_reg.pend;
          r_next.pend     = req;
          r_next.seq_full = 1'b1;
          r_next.seq_rsn  = r_reg.ovf ? `TSW_RSN_OVF
                            : (r_next.ton_pend ? r_next.ton_rsn : `TSW_RSN_PERIODIC);
        end else if (trace_en && r_reg.ton_pend) begin
          r_next.state    = ST_ISYNC;
          r_next.seq_full = 1'b0;
          r_next.seq_rsn  = r_reg.ton_rsn;
        end else if (wp_take && trace_en) begin
          // one update at most: exception-forced or distance, never both
          r_next.state = (WP_EXC_UPD || dif.far) ? ST_WUPD : ST_WPKT;
        end
      end
      ST_ASYNC: begin
        if (forced) begin
          r_next.state = ST_DRAIN;
          r_next.svc   = 4'h0;
        end else if (out_free && FIFO_ROOM) begin
          // whole packet only, so the next byte always starts a packet
          r_next.pkt_valid = 1'b1;
          r_next.pkt_kind  = PK_ASYNC;
          r_next.state     = ST_ISYNC;
        end
      end
      ST_ISYNC: begin
        if (forced) begin
          r_next.state = ST_DRAIN;
          r_next.svc   = 4'h0;
        end else if (out_free && FIFO_ROOM) begin
          r_next.pkt_valid   = 1'b1;
          r_next.pkt_kind    = PK_ISYNC;
          r_next.pkt_rsn     = r_reg.seq_rsn;
          r_next.pkt_addr    = (r_reg.seq_rsn == `TSW_RSN_DEBUG) ? r_reg.dbg_pc
                               : r_reg.last_tgt;
          r_next.pkt_isa     = r_reg.last_isa;
          r_next.pkt_ns      = r_reg.last_ns;
          r_next.pkt_ctx     = CTXID;
          r_next.pkt_ctx_vld = r_reg.ctx_en;
          r_next.pkt_cyc     = r_reg.cyc_wp;
          r_next.pkt_cyc_vld = r_reg.cyc_en
                               && r_reg.seq_rsn != `TSW_RSN_PERIODIC;
          if (r_next.pkt_cyc_vld) begin
            r_next.cyc_run = r_reg.cyc_run - r_reg.cyc_wp;
            r_next.cyc_wp  = '0;
          end
          r_next.ovf      = 1'b0;
          r_next.ton_pend = DBG_EXIT | PROHIB_EXIT | ALT_EXIT; // a fresh exit wins
          r_next.state    = ST_VIRTUAL_MACHINE_IDENTIFIER;
        end
      end
      ST_VIRTUAL_MACHINE_IDENTIFIER: begin
        if (forced) begin
          r_next.state = ST_DRAIN;
          r_next.svc   = 4'h0;
        end else if (out_free) begin
          r_next.pkt_valid = 1'b1;
          r_next.pkt_kind  = PK_VIRTUAL_MACHINE_IDENTIFIER;
          r_next.pkt_vm    = VM_IDENT;
          r_next.state     = r_reg.seq_full ? ST_TSYNC : ST_IDLE;
        end
      end
      ST_TSYNC: begin
        if (forced) begin
          r_next.state = ST_DRAIN;
          r_next.svc   = 4'h0;
        end else if (out_free && FIFO_ROOM) begin
          r_next.pkt_valid = 1'b1;
          r_next.pkt_kind  = PK_TSYNC;
          r_next.pkt_ts    = TIMESTAMP;
          r_next.svc       = 4'h0;
          r_next.state     = ST_IDLE;
        end
      end
      ST_WUPD: begin
        if (out_free) begin
          r_next.pkt_valid = 1'b1;
          r_next.pkt_kind  = PK_WUPD;
          r_next.pkt_addr  = r_reg.upd_addr;
          r_next.state     = ST_WPKT;
        end
      end
      ST_WPKT: begin
        if (out_free) begin
          r_next.pkt_valid = 1'b1;
          r_next.pkt_kind  = PK_WAYPT;
          r_next.pkt_addr  = r_reg.last_tgt;
          r_next.pkt_isa   = r_reg.last_isa;
          r_next.pkt_ns    = r_reg.last_ns;
          r_next.pkt_taken = r_reg.wp_taken;
          r_next.state     = ST_IDLE;
        end
      end
      ST_DRAIN: begin
        // trace stopped; restart only once sink and fifo are both empty
        if (FIFO_EMPTY && !r_reg.pkt_valid) begin
          r_next.ovf   = 1'b1;
          r_next.state = ST_IDLE;
        end
      end
      default: r_next.state = ST_IDLE;
    endcase
  end

  // state other than the synchronizer and distance counter in one register, frozen while the enable is low
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      r_reg <= RST_VAL;
    end else if (CE) begin
      r_reg <= r_next;
    end
  end

  // zero-wait bus slave
  assign PREADY      = 1'b1;
  assign PRDATA      = r_reg.prdata;
  assign PSLVERR     = r_reg.pslverr;
  assign TRACE_STOP  = r_reg.state == ST_DRAIN;
  assign PKT_VALID   = r_reg.pkt_valid;
  assign PKT_KIND    = r_reg.pkt_kind;
  assign PKT_ADDR    = r_reg.pkt_addr;
  assign PKT_REASON  = r_reg.pkt_rsn;
  assign PKT_ISA     = r_reg.pkt_isa;
  assign PKT_NS      = r_reg.pkt_ns;
  assign PKT_TAKEN   = r_reg.pkt_taken;
  assign PKT_CTX     = r_reg.pkt_ctx;
  assign PKT_CTX_VLD = r_reg.pkt_ctx_vld;
  assign PKT_CYC     = r_reg.pkt_cyc;
  assign PKT_CYC_VLD = r_reg.pkt_cyc_vld;
  assign PKT_TS      = r_reg.pkt_ts;
  assign PKT_VM      = r_reg.pkt_vm;
endmodule // tsw_top

// ==== hdl/tsw_cfg.svh ====
`ifndef TSW_CFG_SVH
`define TSW_CFG_SVH

// register byte offsets
`define TSW_OFS_CTRL      12'h000
`define TSW_OFS_OSLOCK    12'h004
`define TSW_OFS_FREQ      12'h008
`define TSW_OFS_STATUS    12'h00c

// control register fields and reset values
`define TSW_CTRL_PROG     0
`define TSW_CTRL_CTXEN    1
`define TSW_CTRL_CYCEN    2
`define TSW_OSLOCK_BIT    0
`define TSW_PROG_RST      1'b1
`define TSW_OSLOCK_RST    1'b1
`define TSW_FREQ_RST      12'h400
`define TSW_PEND_RST      4'h1

// sync request sources, one bit each
`define TSW_SRC_PROG      0
`define TSW_SRC_OSL       1
`define TSW_SRC_CNT       2
`define TSW_SRC_EXT       3

// instruction sync reason codes
`define TSW_RSN_PERIODIC  2'h0
`define TSW_RSN_TURNON    2'h1
`define TSW_RSN_OVF       2'h2
`define TSW_RSN_DEBUG     2'h3

// distance threshold in instruction bytes
`define TSW_DIST_LIMIT    4096

`endif

// ==== hdl/tsw_pkg.sv ====
package tsw_pkg;

  // sequencer states, gray along idle-async-isync-virtual_machine_identifier-tsync
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_ASYNC = 3'h1,
    ST_ISYNC = 3'h3,
    ST_VIRTUAL_MACHINE_IDENTIFIER  = 3'h2,
    ST_TSYNC = 3'h6,
    ST_WUPD  = 3'h7,
    ST_WPKT  = 3'h5,
    ST_DRAIN = 3'h4
  } tsw_state_e;

  // packet kinds on the output stream
  typedef enum logic [2:0] {
    PK_ASYNC  = 3'h0,
    PK_ISYNC  = 3'h1,
    PK_TSYNC  = 3'h2,
    PK_WUPD   = 3'h3,
    PK_WAYPT  = 3'h4,
    PK_VIRTUAL_MACHINE_IDENTIFIER   = 3'h5
  } tsw_pkt_e;

endpackage

// ==== hdl/tsw_dist_if.sv ====
`timescale 1ns/100ps
// link between the sequencer and the byte-distance counter
interface tsw_dist_if;
  logic [2:0] step;
  logic       clr;
  logic       far;
  modport ctl (output step, output clr, input far);
  modport cnt (input step, input clr, output far);
endinterface

// ==== hdl/tsw_sync3.sv ====
`timescale 1ns/100ps
module tsw_sync3 (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic ce,
  input  wire logic d,
  output logic      q
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic q;
  } tsw_sync3_s;

  tsw_sync3_s r_reg;
  tsw_sync3_s r_next;

  // s1 feeds only s2; output moves once s2 and s3 agree
  always_comb begin
    r_next    = r_reg;
    r_next.s1 = d;
    r_next.s2 = r_reg.s1;
    r_next.s3 = r_reg.s2;
    if (r_reg.s2 == r_reg.s3) begin
      r_next.q = r_reg.s3;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r_reg <= '0;
    end else if (ce) begin
      r_reg <= r_next;
    end
  end

  assign q = r_reg.q;
endmodule // tsw_sync3

// ==== hdl/tsw_dist.sv ====
`timescale 1ns/100ps
module tsw_dist #(
  parameter int LIMIT = 4096
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic ce,
  tsw_dist_if.cnt   dif
);
  localparam int CW = $clog2(LIMIT + 8) + 1;

  initial begin
    if (LIMIT < 8) begin
      $error("tsw_dist: LIMIT must be at least 8");
    end
  end

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          far;
  } tsw_dist_s;

  tsw_dist_s r_reg;
  tsw_dist_s r_next;

  // saturate just above the limit so the counter never wraps back to near
  always_comb begin
    r_next = r_reg;
    if (dif.clr) begin
      r_next.cnt = '0;
    end else if (!r_reg.far) begin
      r_next.cnt = r_reg.cnt + CW'(dif.step);
    end
    r_next.far = (r_next.cnt > CW'(LIMIT));
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r_reg <= '0;
    end else if (ce) begin
      r_reg <= r_next;
    end
  end

  assign dif.far = r_reg.far;
endmodule // tsw_dist

// ==== tb/tsw_top_props.sv ====
`timescale 1ns/100ps
`include "tsw_cfg.svh"
module tsw_props
  import tsw_pkg::*;
(
  input wire logic        CLOCK,
  input wire logic        RESETN,
  input wire logic        WP_VALID,
  input wire logic        WP_READY,
  input wire logic [31:0] WP_ADDR,
  input wire logic        WP_ISIZE4,
  input wire logic        DBG_EXIT,
  input wire logic [31:0] DBG_PC,
  input wire logic        FIFO_ROOM,
  input wire logic        TRACE_STOP,
  input wire logic        PKT_VALID,
  input wire logic        PKT_READY,
  input tsw_pkt_e         PKT_KIND,
  input wire logic [31:0] PKT_ADDR,
  input wire logic [1:0]  PKT_REASON,
  input wire logic        PKT_CYC_VLD
);
  logic        acc;
  logic        have_k;
  logic        ovf;
  tsw_pkt_e    last_k;
  logic [31:0] upd_a;
  logic [31:0] dbg_a;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RESETN);
  // a packet changes hands
  assign acc = PKT_VALID && PKT_READY;
  // history; a drain forgets it because the sequence starts over
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      have_k <= 1'b0;
      last_k <= PK_ASYNC;
      ovf    <= 1'b0;
      upd_a  <= 32'h0;
      dbg_a  <= 32'h0;
    end else begin
      have_k <= !TRACE_STOP && (have_k || acc);
      if (acc && !TRACE_STOP) last_k <= PKT_KIND;
      ovf <= TRACE_STOP || (ovf && !(acc && PKT_KIND == PK_ISYNC));
      if (WP_VALID && WP_READY) upd_a <= WP_ADDR - (WP_ISIZE4 ? 32'h4 : 32'h2);
      if (DBG_EXIT) dbg_a <= DBG_PC;
    end
  end
  sync_order_a:
    assert property (acc && have_k && last_k == PK_ASYNC |-> PKT_KIND == PK_ISYNC)
    else $error("alignment packet not followed by instruction sync");
  ident_after_a:
    assert property (acc && have_k && last_k == PK_ISYNC |-> PKT_KIND == PK_VIRTUAL_MACHINE_IDENTIFIER)
    else $error("instruction sync not followed by identifier packet");
  upd_then_wp_a:
    assert property (acc && have_k && last_k == PK_WUPD |-> PKT_KIND == PK_WAYPT)
    else $error("update packet not followed by its waypoint");
  upd_addr_a:
    assert property (PKT_VALID && PKT_KIND == PK_WUPD |-> PKT_ADDR == upd_a)
    else $error("update address is not waypoint minus size");
  no_cycles_a:
    assert property (PKT_VALID && PKT_KIND == PK_ISYNC
      && PKT_REASON == `TSW_RSN_PERIODIC |-> !PKT_CYC_VLD)
    else $error("periodic sync carries a cycle count");
  ovf_reason_a:
    assert property (acc && PKT_KIND == PK_ISYNC && ovf && !TRACE_STOP
      |-> PKT_REASON == `TSW_RSN_OVF)
    else $error("sync after drain lacks overflow reason");
  dbg_addr_a:
    assert property (PKT_VALID && PKT_KIND == PK_ISYNC
      && PKT_REASON == `TSW_RSN_DEBUG |-> PKT_ADDR == dbg_a)
    else $error("debug exit sync address wrong");
  pkt_hold_a:
    assert property (PKT_VALID && !PKT_READY
      |=> PKT_VALID && $stable(PKT_KIND) && $stable(PKT_ADDR))
    else $error("packet changed before it was taken");
  room_wait_a:
    assert property ($rose(PKT_VALID) && PKT_KIND inside {PK_ASYNC, PK_ISYNC, PK_TSYNC}
      |-> $past(FIFO_ROOM))
    else $error("sync packet loaded without fifo room");
  upd_seen_c: cover property (acc && PKT_KIND == PK_WUPD);
  ovf_sync_c: cover property (acc && PKT_KIND == PK_ISYNC && PKT_REASON == `TSW_RSN_OVF);
  drain_c: cover property ($rose(TRACE_STOP));
endmodule // tsw_props
bind tsw_top tsw_props u_props (.CLOCK, .RESETN, .WP_VALID, .WP_READY, .WP_ADDR,
  .WP_ISIZE4, .DBG_EXIT, .DBG_PC, .FIFO_ROOM, .TRACE_STOP, .PKT_VALID, .PKT_READY,
  .PKT_KIND, .PKT_ADDR, .PKT_REASON, .PKT_CYC_VLD);

// ==== tb/tsw_sink.sv ====
`timescale 1ns/100ps
module tsw_sink
  import tsw_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        stall,
  input  wire logic        room_lo,
  input  wire logic        valid,
  input  tsw_pkt_e         kind,
  input  wire logic [1:0]  reason,
  input  wire logic [31:0] addr,
  output logic             ready,
  output logic             room,
  output logic             empty,
  output logic             full
);
  logic [7:0]  lvl;
  tsw_pkt_e    kq[$];
  logic [33:0] dq[$];
  // a backed-up sink has neither room nor an empty fifo
  assign ready = !stall;
  assign room  = !room_lo;
  assign empty = lvl == 8'h0 && !room_lo;
  assign full  = 1'b0; // never full; overflow is only ever forced by a repeated request
  // take packets, draining one unit per cycle
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lvl <= 8'h0;
    end else begin
      if (valid && ready) kq.push_back(kind);
      if (valid && ready) dq.push_back({reason, addr});
      lvl <= lvl + {7'h0, valid && ready} - {7'h0, lvl != 8'h0};
    end
  end
endmodule // tsw_sink

// ==== tb/trace_sync_waypoint_update_test.sv ====
`timescale 1ns/100ps
`include "tsw_cfg.svh"
`define CHK(g, w) begin n_compared++; if ((g) !== (w)) begin err_total++; \
  $display("unexpected at %0t: got %h want %h", $time, (g), (w)); end end
module trace_sync_waypoint_update_test
  import tsw_pkg::*;
;
  logic        clk, rst_n, psel, penable, pwrite, trace_on, dbg, prh, alt, ext;
  logic        wp_valid, wp_isize4, wp_taken, wp_exc, wp_ns, stall, room_lo, er;
  logic        pready, pslverr, wp_ready, trace_stop, pkt_valid, pkt_ready;
  logic        room, empty, full;
  logic [11:0] paddr;
  logic [31:0] pwdata, dbg_pc, wp_addr, wp_target, ctxid, rd, prdata, pkt_addr;
  logic [7:0]  vm;
  logic [63:0] ts;
  logic [2:0]  insn;
  logic [1:0]  wp_isa, pkt_reason;
  tsw_pkt_e    pkt_kind;
  int          err_total, n_compared;
  integer      seed = 32'h70af;
  tsw_top #(.LIMIT(16)) DUT (.CLOCK(clk), .RESETN(rst_n), .CE(1'b1),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .TRACE_ON(trace_on),
    .DBG_EXIT(dbg), .DBG_PC(dbg_pc), .PROHIB_EXIT(prh), .ALT_EXIT(alt),
    .EXT_SYNC_REQ(ext), .INSN_BYTES(insn), .WP_VALID(wp_valid), .WP_READY(wp_ready),
    .WP_ADDR(wp_addr), .WP_ISIZE4(wp_isize4), .WP_TARGET(wp_target), .WP_ISA(wp_isa),
    .WP_NS(wp_ns), .WP_TAKEN(wp_taken), .WP_EXC_UPD(wp_exc), .CTXID(ctxid),
    .VM_IDENT(vm), .TIMESTAMP(ts), .FIFO_ROOM(room), .FIFO_EMPTY(empty),
    .FIFO_FULL(full), .TRACE_STOP(trace_stop), .PKT_VALID(pkt_valid),
    .PKT_READY(pkt_ready), .PKT_KIND(pkt_kind), .PKT_ADDR(pkt_addr),
    .PKT_REASON(pkt_reason), .PKT_ISA(), .PKT_NS(), .PKT_TAKEN(), .PKT_CTX(),
    .PKT_CTX_VLD(), .PKT_CYC(), .PKT_CYC_VLD(), .PKT_TS(), .PKT_VM());
  tsw_sink snk (.clk(clk), .rst_n(rst_n), .stall(stall), .room_lo(room_lo),
    .valid(pkt_valid), .kind(pkt_kind), .reason(pkt_reason), .addr(pkt_addr),
    .ready(pkt_ready), .room(room), .empty(empty), .full(full));
  // 250 MHz
  always #2 clk = ~clk;
  // random sink pacing and payloads the block only passes on
  always @(posedge clk) begin
    stall <= ($random(seed) & 3) == 0;
    ctxid <= $random(seed);
    vm <= $random(seed);
    ts <= {$random(seed), $random(seed)};
    wp_target <= $random(seed);
    {wp_taken, wp_ns, wp_isa} <= $random(seed);
  end
  task automatic test_done;
    $display("compared %0d mismatched %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic hang;
    err_total++;
    test_done;
  endtask
  // one apb transfer; held until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge clk);
    penable <= 1'b1;
    @(negedge clk);
    for (int i = 0; i < 20 && pready !== 1'b1; i++) @(negedge clk);
    if (pready !== 1'b1) hang;
    @(posedge clk);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic wp(input logic [31:0] a, input logic s4, input logic x);
    {wp_valid, wp_addr, wp_isize4, wp_exc} <= {1'b1, a, s4, x};
    @(negedge clk);
    for (int i = 0; i < 300 && wp_ready !== 1'b1; i++) @(negedge clk);
    if (wp_ready !== 1'b1) hang;
    @(posedge clk);
    wp_valid <= 1'b0;
  endtask
  task automatic take(output tsw_pkt_e k, output logic [33:0] d);
    for (int i = 0; i < 5000 && snk.kq.size() == 0; i++) @(posedge clk);
    if (snk.kq.size() == 0) hang;
    k = snk.kq.pop_front();
    d = snk.dq.pop_front();
  endtask
  task automatic per_seq(input logic [1:0] r);
    tsw_pkt_e    k;
    logic [33:0] d;
    take(k, d);
    `CHK(k, PK_ASYNC)
    take(k, d);
    `CHK(k, PK_ISYNC)
    `CHK(d[33:32], r)
    take(k, d);
    `CHK(k, PK_VIRTUAL_MACHINE_IDENTIFIER)
    take(k, d);
    `CHK(k, PK_TSYNC)
    $display("sync sequence test done");
  endtask
  // drop leftovers of merged requests
  task automatic flush;
    repeat (60) @(posedge clk);
    snk.kq.delete();
    snk.dq.delete();
  endtask
  task automatic pulse_ext;
    ext <= 1'b1;
    repeat (6) @(posedge clk);
    ext <= 1'b0;
    repeat (6) @(posedge clk);
  endtask
  task automatic wait_stop(input logic v);
    for (int i = 0; i < 300 && trace_stop !== v; i++) @(posedge clk);
    if (trace_stop !== v) hang;
  endtask
  // main sequence
  initial begin
    tsw_pkt_e    k;
    logic [33:0] d;
    logic [31:0] a;
    {psel, penable, pwrite, trace_on, dbg, prh, alt, ext, wp_valid, wp_isize4} = '0;
    {wp_taken, wp_exc, wp_ns, stall, room_lo, rst_n, clk, paddr, pwdata} = '0;
    {dbg_pc, wp_addr, wp_target, ctxid, vm, ts, insn, wp_isa} = '0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, `TSW_OFS_CTRL, 32'h0);
    `CHK(rd[0], `TSW_PROG_RST)
    apb(1'b0, `TSW_OFS_FREQ, 32'h0);
    `CHK(rd[11:0], `TSW_FREQ_RST)
    apb(1'b0, 12'h010, 32'h0);
    `CHK({er, rd}, 33'h100000000)
    apb(1'b1, `TSW_OFS_FREQ, 32'h0);
    trace_on <= 1'b1;
    apb(1'b1, `TSW_OFS_OSLOCK, 32'h0);
    apb(1'b1, `TSW_OFS_CTRL, 32'h6);
    per_seq(`TSW_RSN_TURNON);
    flush;
    // far and exception waypoints in all combinations, first one from the sync
    for (int i = 0; i < 4; i++) begin
      a = $random(seed);
      insn <= i[0] ? 3'h7 : 3'h0;
      repeat (4) @(posedge clk);
      insn <= 3'h0;
      wp(a, a[0], i[1]);
      if (i != 0) begin
        take(k, d);
        `CHK(k, PK_WUPD)
        `CHK(d[31:0], a - (a[0] ? 32'h4 : 32'h2))
      end
      take(k, d);
      `CHK(k, PK_WAYPT)
    end
    $display("waypoint update test done");
    // each restart reason gets its own instruction sync
    for (int j = 0; j < 3; j++) begin
      a = $random(seed);
      dbg_pc <= a;
      @(posedge clk);
      {dbg, prh, alt} <= 3'h1 << (2 - j);
      @(posedge clk);
      {dbg, prh, alt} <= 3'h0;
      take(k, d);
      `CHK(k, PK_ISYNC)
      `CHK(d[33:32], j == 0 ? `TSW_RSN_DEBUG : `TSW_RSN_TURNON)
      if (j == 0) `CHK(d[31:0], a)
      take(k, d);
      `CHK(k, PK_VIRTUAL_MACHINE_IDENTIFIER)
    end
    apb(1'b1, `TSW_OFS_FREQ, 32'h40);
    per_seq(`TSW_RSN_PERIODIC);
    apb(1'b1, `TSW_OFS_FREQ, 32'h0);
    flush;
    trace_on <= 1'b0;
    pulse_ext;
    repeat (30) @(posedge clk);
    `CHK(snk.kq.size(), 0)
    trace_on <= 1'b1;
    per_seq(`TSW_RSN_TURNON);
    flush;
    // second request from the same source while the first waits for room
    room_lo <= 1'b1;
    pulse_ext;
    pulse_ext;
    wait_stop(1'b1);
    `CHK(trace_stop, 1'b1)
    room_lo <= 1'b0;
    wait_stop(1'b0);
    snk.kq.delete();
    snk.dq.delete();
    per_seq(`TSW_RSN_OVF);
    test_done;
  end
  // cut a hang short
  initial begin
    repeat (80000) @(posedge clk);
    hang;
  end
endmodule // trace_sync_waypoint_update_test
